// [rtl/zsx_pkg.sv]
package zsx_pkg;
  // Opcode upper-byte patterns
  localparam logic [6:0] OPC_TEST_HI  = 7'h36;   // 011a 0110 without a
  localparam logic [7:0] OPC_XOR_HI   = 8'h0A;   // 0000 1010
  localparam int         BANK_BIT     = 8;       // Bit the checker reads as a; decode takes a from bit 12
  localparam logic [7:0] IDX_LIMIT    = 8'h5F;   // Indexed offset limit
  localparam logic [7:0] ACC_SPLIT    = 8'h80;   // Access bank low/high
  localparam logic [3:0] ACC_HI_BANK  = 4'hF;    // Bank of upper access half
  localparam logic [7:0] W_RESET      = 8'h00;
  localparam int         Q_PHASES     = 4;       // Quarters per cycle
  localparam logic [1:0] Q_LAST       = 2'h3;
  // Execution phase of the current instruction cycle
  typedef enum logic [1:0] {ZSX_EXEC, ZSX_FLUSH1, ZSX_FLUSH2} zsx_state_type;
endpackage

// [rtl/zsx_if.sv]
`timescale 1ns/1ps
interface zsx_if;
  logic       qStart;
  logic [1:0] qPhase;
  modport src (output qStart, output qPhase);
  modport dst (input qStart, input qPhase);
endinterface

// [rtl/zsx_quarter_gen.sv]
`timescale 1ns/1ps
module zsx_quarter_gen
  import zsx_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  zsx_if.src       q
);
  logic [1:0] phase_ff;

  // Four-quarter sequencer; qStart pulses at Q4 of each cycle
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      phase_ff <= 2'h0;
    else
      phase_ff <= phase_ff + 2'h1;
  end

  assign q.qPhase = phase_ff;
  assign q.qStart = (phase_ff == Q_LAST);
endmodule // zsx_quarter_gen

// [rtl/zsx_exec.sv]
// Contract
// - Zero byte: discard prefetch, run no-op
// - Two-word follower flushed: three cycles total
// - Decode 011a0110; test leaves flags untouched
// - a clear: operand from access bank
// - a set: bank select register plus address
// - Extended, a clear, f<=5F: indexed offset
// - One word; one cycle, two on skip
// - XOR immediate into accumulator, write back
// - Decode 00001010; only N and Z change
`timescale 1ns/1ps
module zsx_exec
  import zsx_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        instrValid,
  input  wire logic [15:0] instrWord,
  input  wire logic        nextIsTwoWord,
  input  wire logic        extendedEnable,
  input  wire logic [3:0]  bankSelect,
  input  wire logic [11:0] indexBase,
  input  wire logic [7:0]  memReadData,
  output logic [11:0]      memAddr_ff,
  output logic             memRead_ff,
  output logic [7:0]       accumulator_ff,
  output logic             flagNeg_ff,
  output logic             flagZero_ff,
  output logic             discardFetch_ff,
  output logic             nopCycle_ff,
  output logic             busy_ff
);
  import zsx_pkg::*;

  // Timing model, one instruction cycle = four clocks (Q1..Q4):
  //  - qStart marks the last quarter; all architectural state moves
  //    on that edge only, so every output stands for a whole cycle.
  //  - A test instruction is decoded at one boundary and its operand
  //    byte is judged at the next, once the memory has answered.
  //  - A zero byte turns the following one or two cycles into no-op
  //    slots; the accumulator and flags are not written while they run, and only a test decoded at the first slot's opening edge reads in it.
  // Limitation: the two-word flag is only looked at during the first
  // flush slot, so the fetch side must present it by then.

  zsx_if qBus ();
  zsx_state_type state_ff;
  zsx_state_type nxt_state;
  logic       isTest;
  logic       isXor;
  logic       bankBit;
  logic [7:0] fileAddr;
  logic [11:0] nxt_addr;
  logic [7:0] xorResult;
  logic       skipNow;
  logic       testPending_ff;
  logic [11:0] bankedAddr;
  logic [11:0] indexedAddr;
  logic [11:0] accessAddr;
  logic        useIndexed;
  logic        execSlot;
  logic        nxt_flush;

  zsx_quarter_gen uQuarter (
    .clock (clock),
    .nrst  (nrst),
    .q     (qBus.src)
  );

  assign isTest   = instrValid && (instrWord[15:13] == OPC_TEST_HI[6:4])
                    && (instrWord[11:8] == OPC_TEST_HI[3:0]);
  assign isXor    = instrValid && (instrWord[15:8] == OPC_XOR_HI);
  assign bankBit  = instrWord[12];
  assign fileAddr = instrWord[7:0];
  assign xorResult = accumulator_ff ^ instrWord[7:0];

  assign bankedAddr  = {bankSelect, fileAddr};
  // indexed literal offset
  // The sum wraps within 12 bits; an address past the top continues from zero
  assign indexedAddr = indexBase + {4'h0, fileAddr};
  // access bank halves
  // Low half is bank 0, high half the top bank
  assign accessAddr  = (fileAddr < ACC_SPLIT) ? {4'h0, fileAddr}
                                              : {ACC_HI_BANK, fileAddr};
  // Indexed mode only replaces the access bank, never the banked form
  assign useIndexed  = extendedEnable && (fileAddr <= IDX_LIMIT);

  // Operand address formation; banked wins, then indexed, then access
  always_comb
  begin
    if (bankBit)
      nxt_addr = bankedAddr;
    else if (useIndexed)
      nxt_addr = indexedAddr;
    else
      nxt_addr = accessAddr;
  end

  // Only a normal cycle may decode; flush slots are dead time
  assign execSlot  = (state_ff == ZSX_EXEC);
  // Any state but EXEC next means the coming cycle is a no-op
  assign nxt_flush = (nxt_state != ZSX_EXEC);

  // Read request in Q1, data used at Q4 of the same cycle
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      memAddr_ff     <= 12'h000;
      memRead_ff     <= 1'b0;
      testPending_ff <= 1'b0;
    end
    else if (qBus.qStart)
    begin
      memAddr_ff     <= nxt_addr;
      memRead_ff     <= isTest && execSlot;
      testPending_ff <= isTest && execSlot;
    end
  end

  assign skipNow = testPending_ff && (memReadData == 8'h00);

  // Cycle sequencing
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ZSX_EXEC:
        if (skipNow)
          nxt_state = ZSX_FLUSH1;
      ZSX_FLUSH1:
        nxt_state = nextIsTwoWord ? ZSX_FLUSH2 : ZSX_EXEC;
      ZSX_FLUSH2:
        nxt_state = ZSX_EXEC;
      default:
        nxt_state = ZSX_EXEC;
    endcase
  end

  // State moves at the cycle boundary only
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      state_ff <= ZSX_EXEC;
    else if (qBus.qStart)
      state_ff <= nxt_state;
  end

  // Fetch discard marker, held for each flushed cycle
  // Kept as its own flop so the fetch side sees a clean level
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      discardFetch_ff <= 1'b0;
    else if (qBus.qStart)
      discardFetch_ff <= nxt_flush;
  end

  // No-op marker for each slot run in place of a fetched word
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      nopCycle_ff <= 1'b0;
    else if (qBus.qStart)
      nopCycle_ff <= nxt_flush;
  end

  // Busy marker; stalls the fetch side while slots are burnt
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      busy_ff <= 1'b0;
    else if (qBus.qStart)
      busy_ff <= nxt_flush;
  end

  // Accumulator and flags written at Q4; no-op cycles write nothing
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      accumulator_ff <= W_RESET;
      flagNeg_ff     <= 1'b0;
      flagZero_ff    <= 1'b0;
    end
    else if (qBus.qStart && isXor && execSlot)
    begin
      accumulator_ff <= xorResult;
      flagNeg_ff     <= xorResult[7];
      flagZero_ff    <= (xorResult == 8'h00);
    end
  end
endmodule // zsx_exec

// [verif/zsx_exec_chk.sv]
`timescale 1ns/1ps
module zsx_exec_chk
  import zsx_pkg::*;
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [15:0] instrWord,
  input wire logic [3:0]  bankSelect,
  input wire logic [7:0]  memReadData,
  input wire logic [11:0] memAddr_ff,
  input wire logic        memRead_ff,
  input wire logic [7:0]  accumulator_ff,
  input wire logic        flagNeg_ff,
  input wire logic        flagZero_ff,
  input wire logic        discardFetch_ff,
  input wire logic        nopCycle_ff,
  input wire logic        busy_ff
);
  // One domain, so clock and reset are given once
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_xor; $changed(accumulator_ff) |-> accumulator_ff ==
    ($past(accumulator_ff) ^ $past(instrWord[7:0])); endproperty
  a_xor: assert property (p_xor) else $error("xor result");
  property p_nz; $changed(accumulator_ff) |-> flagNeg_ff ==
    accumulator_ff[7] && flagZero_ff == (accumulator_ff == 8'h00); endproperty
  a_nz: assert property (p_nz) else $error("flag value");
  property p_flg; $changed({flagNeg_ff, flagZero_ff}) |->
    $past(instrWord[15:8]) == OPC_XOR_HI; endproperty
  a_flg: assert property (p_flg) else $error("flag source");
  property p_n4; $rose(nopCycle_ff) |-> nopCycle_ff[*4]; endproperty
  a_n4: assert property (p_n4) else $error("no-op short");
  property p_n8; $rose(nopCycle_ff) |-> ##[4:8] !nopCycle_ff; endproperty
  a_n8: assert property (p_n8) else $error("no-op long");
  property p_nr; $rose(nopCycle_ff) |->
    $past(memRead_ff) && $past(memReadData) == 8'h00; endproperty
  a_nr: assert property (p_nr) else $error("no-op cause");
  property p_bk; $rose(memRead_ff) && $past(instrWord[BANK_BIT]) |->
    memAddr_ff == {$past(bankSelect), $past(instrWord[7:0])}; endproperty
  a_bk: assert property (p_bk) else $error("bank address");
  property p_eq; discardFetch_ff == nopCycle_ff && busy_ff == nopCycle_ff;
  endproperty
  a_eq: assert property (p_eq) else $error("flush flags");
endmodule // zsx_exec_chk
bind zsx_exec zsx_exec_chk u_chk (.*);

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import zsx_pkg::*;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        instrValid = 1'b1;
  logic [15:0] instrWord = 16'h0000;
  logic        nextIsTwoWord = 1'b0;
  logic        extendedEnable = 1'b0;
  logic [3:0]  bankSelect = 4'h0;
  logic [11:0] indexBase = 12'h100;
  logic [7:0]  memReadData = 8'h00;
  logic [11:0] memAddr_ff;
  logic [7:0]  accumulator_ff;
  logic        memRead_ff, flagNeg_ff, flagZero_ff;
  logic        discardFetch_ff, nopCycle_ff, busy_ff;
  int          error_cnt = 0;
  int          samples_checked = 0;
  zsx_exec u_dut (.*);
  // Free-running clock, 20 ns period
  initial forever #10 clock = ~clock;
  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, s, e);
    end
  endtask
  // One instruction cycle; ends just after its closing edge
  task automatic issue(input logic [15:0] w, input logic [7:0] d,
                       input logic t);
    @(posedge clock);
    instrWord <= w;
    memReadData <= d;
    nextIsTwoWord <= t;
    repeat (3) @(posedge clock);
    #1;
  endtask
  // Test a byte, then count flush cycles; Z flag must not move
  task automatic tst(input logic [15:0] w, input logic x, input logic [7:0] d,
                     input logic t, input logic [11:0] a, input int n);
    logic z;
    z = flagZero_ff;
    extendedEnable <= x;
    issue(w, 8'hA5, 1'b0);
    chk(memAddr_ff, a);
    chk(memRead_ff, 1'b1);
    issue(16'h0000, d, t);
    for (int i = 1; i <= 3; i++)
    begin
      chk(nopCycle_ff, i <= n);
      chk(flagZero_ff, z);
      issue(16'h0000, 8'h00, t);
    end
  endtask
  task automatic scn_xor();
    issue(16'h0AAF, 8'h00, 1'b0);
    chk(accumulator_ff, 8'hAF);
    chk({flagNeg_ff, flagZero_ff}, 2'h2);
    issue(16'h0AAF, 8'h00, 1'b0);
    chk({accumulator_ff, flagNeg_ff, flagZero_ff}, 10'h001);
  endtask
  task automatic summarize();
    $display("mismatches %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Whole run is well under 100 instruction cycles
  initial
  begin
    #20000;
    error_cnt++;
    summarize();
  end
  initial
  begin
    repeat (2) @(posedge clock);
    bankSelect <= 4'h5;
    nrst <= 1'b1;
    chk(accumulator_ff, W_RESET);
    scn_xor();
    tst(16'h763C, 1'b0, 8'h05, 1'b0, 12'h53C, 0);
    tst(16'h6690, 1'b0, 8'h00, 1'b0, 12'hF90, 1);
    tst(16'h6610, 1'b1, 8'h00, 1'b1, 12'h110, 2);
    tst(16'h6660, 1'b1, 8'h01, 1'b1, 12'h060, 0);
    summarize();
  end
endmodule // tb_top
